// ===== pkg/bmm_consts.svh
// Opcode patterns, field positions, reset values and phase timing for the byte move/multiply execution block.
// Assumes a 16-bit instruction word and a 12-bit data-memory byte address.
`ifndef BMM_CONSTS_SVH
`define BMM_CONSTS_SVH

// ==========================================
// Opcode patterns
`define BMM_OP_LIT_HI      8'h0E
`define BMM_OP_MULLIT_HI   8'h0D
`define BMM_OP_STORE_HI    7'h37
`define BMM_OP_MULFILE_HI  7'h01

// ==========================================
// Field positions
`define BMM_OP8_MSB        15
`define BMM_OP8_LSB        8
`define BMM_OP7_LSB        9
`define BMM_ABIT_POS       8
`define BMM_FIELD_MSB      7

// ==========================================
// Addressing
`define BMM_IDX_LIMIT      8'h5F
`define BMM_ACCESS_SPLIT   8'h80
`define BMM_ACCESS_LO_BANK 4'h0
`define BMM_ACCESS_HI_BANK 4'hF

// ==========================================
// Reset values
`define BMM_ACC_RST        8'h00
`define BMM_PROD_RST       16'h0000

// ==========================================
// Timing
`define BMM_CLK_NS         8
`define BMM_PHASES         4

`endif

// ===== pkg/bmm_pkg.sv
// Types shared by the byte move/multiply execution block.
// Assumes bmm_consts.svh is compiled alongside.
package bmm_pkg;

  // ==========================================
  // Instruction cycle phases
  typedef enum logic [3:0] {
    BMM_Q1 = 4'h1,
    BMM_Q2 = 4'h2,
    BMM_Q3 = 4'h4,
    BMM_Q4 = 4'h8
  } bmm_phase_t;

  // ==========================================
  // Decoded operation
  typedef enum logic [4:0] {
    BMM_OP_NONE    = 5'h01,
    BMM_OP_LIT     = 5'h02,
    BMM_OP_STORE   = 5'h04,
    BMM_OP_MULLIT  = 5'h08,
    BMM_OP_MULFILE = 5'h10
  } bmm_op_t;

  typedef struct packed {
    bmm_op_t    op;
    logic       access_sel;
    logic [7:0] field;
    logic [11:0] addr;
  } bmm_dec_t;

  // ==========================================
  // Data-memory request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } bmm_mem_req_t;

endpackage : bmm_pkg

// ===== rtl/bmm_addr_resolve.sv
// Resolves an 8-bit file field and access bit into a 12-bit data-memory address.
// Assumes bank select and index base are stable during the decode phase.
`timescale 1ns/1ns
`include "bmm_consts.svh"

module bmm_addr_resolve (
  input  wire logic [7:0]  i_field,
  input  wire logic        i_access_sel,
  input  wire logic        i_ext_en,
  input  wire logic [3:0]  i_bank_sel,
  input  wire logic [11:0] i_index_base,
  output logic      [11:0] o_addr,
  output logic             o_indexed
);

  // ==========================================
  // Address selection
  wire logic        idx_hit;
  wire logic        low_half;
  wire logic [11:0] bank_addr;
  wire logic [11:0] access_addr;
  wire logic [11:0] index_addr;

  assign idx_hit     = (i_field <= `BMM_IDX_LIMIT);
  assign o_indexed   = !i_access_sel && i_ext_en && idx_hit;
  assign low_half    = (i_field < `BMM_ACCESS_SPLIT);
  // Every field value 0..255 maps somewhere; nothing is refused
  assign bank_addr   = {i_bank_sel, i_field};
  assign access_addr = {low_half ? `BMM_ACCESS_LO_BANK : `BMM_ACCESS_HI_BANK, i_field};
  // Wraps modulo 4K, as the data space does
  assign index_addr  = i_index_base + {4'h0, i_field};
  assign o_addr      = o_indexed    ? index_addr :
                       i_access_sel ? bank_addr  : access_addr;

endmodule // bmm_addr_resolve

// ===== rtl/bmm_exec.sv
// Execution logic for literal load, store of the working register and unsigned multiply.
// Assumes the core presents one instruction word in phase one and a data memory with one-cycle read latency.
`timescale 1ns/1ns
`include "bmm_consts.svh"

// How it works
// - Literal-load opcode 0x0E puts its 8-bit literal into the working register.
// - Store copies the working register to the addressed byte; register unchanged.
// - Any file address 0 to 255 is accepted within the selected bank.
// - Access bit 0 resolves the address in the access bank.
// - Access bit 1 uses the bank select register to choose the bank.
// - Access bit 0, extended set on, address up to 0x5F: indexed offset mode.
// - Store is recognised from upper bits 0110111, access bit, 8-bit address.
// - Store leaves every arithmetic status flag untouched.
module bmm_exec #(
  parameter int unsigned DATA_W = 8
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_SYS_RST,
  input  wire logic                 I_INSTR_VALID,
  input  wire logic [15:0]          I_INSTR,
  input  wire logic                 I_EXT_EN,
  input  wire logic [3:0]           I_BANK_SEL,
  input  wire logic [11:0]          I_INDEX_BASE,
  input  wire logic [DATA_W-1:0]    I_MEM_RDATA,
  output bmm_pkg::bmm_mem_req_t     O_MEM_REQ,
  output bmm_pkg::bmm_phase_t       O_PHASE,
  output logic      [DATA_W-1:0]    O_ACC,
  output logic      [DATA_W-1:0]    O_PROD_HI,
  output logic      [DATA_W-1:0]    O_PROD_LO,
  output logic                      O_FLAGS_WE,
  output logic                      O_DONE,
  output logic                      O_ILLEGAL
);

  // ==========================================
  // Phase sequencer
  bmm_pkg::bmm_phase_t phase_r;
  bmm_pkg::bmm_phase_t phase_nxt;

  always_comb begin
    case (phase_r)
      bmm_pkg::BMM_Q1: phase_nxt = bmm_pkg::BMM_Q2;
      bmm_pkg::BMM_Q2: phase_nxt = bmm_pkg::BMM_Q3;
      bmm_pkg::BMM_Q3: phase_nxt = bmm_pkg::BMM_Q4;
      bmm_pkg::BMM_Q4: phase_nxt = bmm_pkg::BMM_Q1;
      default:         phase_nxt = bmm_pkg::BMM_Q1;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      phase_r <= bmm_pkg::BMM_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  wire logic in_q1;
  wire logic in_q2;
  wire logic in_q3;
  wire logic in_q4;

  assign in_q1 = (phase_r == bmm_pkg::BMM_Q1);
  assign in_q2 = (phase_r == bmm_pkg::BMM_Q2);
  assign in_q3 = (phase_r == bmm_pkg::BMM_Q3);
  assign in_q4 = (phase_r == bmm_pkg::BMM_Q4);

  // ==========================================
  // Decode
  wire logic [7:0]      op8;
  wire logic [6:0]      op7;
  wire logic            is_lit;
  wire logic            is_mullit;
  wire logic            is_store;
  wire logic            is_mulfile;
  wire logic [7:0]      field;
  wire logic            access_sel;
  wire logic [11:0]     res_addr;
  bmm_pkg::bmm_op_t     dec_op;

  assign op8        = I_INSTR[`BMM_OP8_MSB:`BMM_OP8_LSB];
  assign op7        = I_INSTR[`BMM_OP8_MSB:`BMM_OP7_LSB];
  assign field      = I_INSTR[`BMM_FIELD_MSB:0];
  assign access_sel = I_INSTR[`BMM_ABIT_POS];
  assign is_lit     = (op8 == `BMM_OP_LIT_HI);
  assign is_mullit  = (op8 == `BMM_OP_MULLIT_HI);
  assign is_store   = (op7 == `BMM_OP_STORE_HI);
  assign is_mulfile = (op7 == `BMM_OP_MULFILE_HI);
  assign dec_op     = is_lit     ? bmm_pkg::BMM_OP_LIT     :
                      is_mullit  ? bmm_pkg::BMM_OP_MULLIT  :
                      is_store   ? bmm_pkg::BMM_OP_STORE   :
                      is_mulfile ? bmm_pkg::BMM_OP_MULFILE : bmm_pkg::BMM_OP_NONE;

  bmm_addr_resolve u_addr (
    .i_field      (field),
    .i_access_sel (access_sel),
    .i_ext_en     (I_EXT_EN),
    .i_bank_sel   (I_BANK_SEL),
    .i_index_base (I_INDEX_BASE),
    .o_addr       (res_addr),
    .o_indexed    ()
  );

  bmm_pkg::bmm_dec_t dec_r;
  bmm_pkg::bmm_dec_t dec_nxt;
  wire logic         take;

  // Word is only taken in Q1; a valid outside Q1 is ignored
  assign take = in_q1 && I_INSTR_VALID;

  always_comb begin
    dec_nxt = dec_r;
    if (take) begin
      dec_nxt.op         = dec_op;
      dec_nxt.access_sel = access_sel;
      dec_nxt.field      = field;
      dec_nxt.addr       = res_addr;
    end else if (in_q1) begin
      // Clear the word too, or an idle group would flag stale bits as illegal
      dec_nxt.op         = bmm_pkg::BMM_OP_NONE;
      dec_nxt.access_sel = 1'b0;
      dec_nxt.field      = 8'h00;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      dec_r <= '{op: bmm_pkg::BMM_OP_NONE, access_sel: 1'b0, field: 8'h00, addr: 12'h000};
    end else begin
      dec_r <= dec_nxt;
    end
  end

  // ==========================================
  // Operand path
  wire logic is_file_mul;
  wire logic is_store_r;
  logic [DATA_W-1:0] opnd_r;
  logic              pend_r;

  assign is_file_mul = (dec_r.op == bmm_pkg::BMM_OP_MULFILE);
  assign is_store_r  = (dec_r.op == bmm_pkg::BMM_OP_STORE);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      opnd_r <= '0;
      pend_r <= 1'b0;
    end else begin
      pend_r <= in_q1 && take;
      if (in_q3) begin
        opnd_r <= is_file_mul ? I_MEM_RDATA : dec_r.field[DATA_W-1:0];
      end
    end
  end

  // ==========================================
  // Memory request
  bmm_pkg::bmm_mem_req_t mem_r;
  bmm_pkg::bmm_mem_req_t mem_nxt;
  logic [DATA_W-1:0]     acc_r;

  always_comb begin
    mem_nxt    = mem_r;
    mem_nxt.rd = 1'b0;
    mem_nxt.wr = 1'b0;
    if (in_q1 && take) begin
      mem_nxt.addr = res_addr;
      // Store also reads in Q2; the data is dropped but the read cycle matches the core's
      mem_nxt.rd   = is_store || is_mulfile;
    end
    if (in_q3 && is_store_r) begin
      mem_nxt.wdata = acc_r;
      mem_nxt.wr    = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      mem_r <= '{addr: 12'h000, wdata: 8'h00, rd: 1'b0, wr: 1'b0};
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // ==========================================
  // Unsigned multiplier, one shifted partial product per multiplier bit
  logic [2*DATA_W-1:0] part [DATA_W];
  logic [2*DATA_W-1:0] sum  [DATA_W+1];

  assign sum[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_pp
      assign part[gi]  = opnd_r[gi] ? ({{DATA_W{1'b0}}, acc_r} << gi) : '0;
      assign sum[gi+1] = sum[gi] + part[gi];
    end
  endgenerate

  // ==========================================
  // Working register and product pair
  logic [2*DATA_W-1:0] prod_r;
  logic                done_r;
  logic                illegal_r;
  wire logic           do_lit;
  wire logic           do_mul;

  assign do_lit = in_q4 && (dec_r.op == bmm_pkg::BMM_OP_LIT);
  assign do_mul = in_q4 && (dec_r.op == bmm_pkg::BMM_OP_MULLIT || is_file_mul);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      acc_r <= `BMM_ACC_RST;
    end else if (do_lit) begin
      acc_r <= dec_r.field[DATA_W-1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      prod_r <= `BMM_PROD_RST;
    end else if (do_mul) begin
      prod_r <= sum[DATA_W];
    end
  end

  // Done and illegal are one-cycle pulses during the next Q1
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      done_r    <= in_q4 && (dec_r.op != bmm_pkg::BMM_OP_NONE) && !pend_r;
      illegal_r <= in_q4 && (dec_r.op == bmm_pkg::BMM_OP_NONE) && (dec_r.field != 8'h00 || dec_r.access_sel);
    end
  end

  // ==========================================
  // Outputs
  assign O_MEM_REQ  = mem_r;
  assign O_PHASE    = phase_r;
  assign O_ACC      = acc_r;
  assign O_PROD_HI  = prod_r[2*DATA_W-1:DATA_W];
  assign O_PROD_LO  = prod_r[DATA_W-1:0];
  // None of these instructions touches a status flag
  assign O_FLAGS_WE = 1'b0;
  assign O_DONE     = done_r;
  assign O_ILLEGAL  = illegal_r;

endmodule // bmm_exec

// ===== verif/bmm_exec_checker.sv
// Port assertions for the byte move/multiply execution block.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ns
module bmm_exec_checker #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic              I_CLK,
  input wire logic              I_SYS_RST,
  input wire logic              I_INSTR_VALID,
  input wire logic [15:0]       I_INSTR,
  input wire logic              I_EXT_EN,
  input wire logic [3:0]        I_BANK_SEL,
  input wire logic [11:0]       I_INDEX_BASE,
  input wire logic [DATA_W-1:0] I_MEM_RDATA,
  input bmm_pkg::bmm_mem_req_t  O_MEM_REQ,
  input bmm_pkg::bmm_phase_t    O_PHASE,
  input wire logic [DATA_W-1:0] O_ACC,
  input wire logic [DATA_W-1:0] O_PROD_HI,
  input wire logic [DATA_W-1:0] O_PROD_LO,
  input wire logic              O_FLAGS_WE,
  input wire logic              O_DONE,
  input wire logic              O_ILLEGAL
);
  // ====
  // Request decode
  wire logic take = I_INSTR_VALID && (O_PHASE == bmm_pkg::BMM_Q1);
  wire logic st   = take && (I_INSTR[15:9] == 7'h37);
  wire logic idx  = I_EXT_EN && (I_INSTR[7:0] <= 8'h5F);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ====
  // Properties
  a_phase_order: assert property (O_PHASE == bmm_pkg::BMM_Q1 |=> O_PHASE == bmm_pkg::BMM_Q2 ##1
    O_PHASE == bmm_pkg::BMM_Q3 ##1 O_PHASE == bmm_pkg::BMM_Q4 ##1 O_PHASE == bmm_pkg::BMM_Q1) else $error("phase order");
  a_lit_load: assert property (take && I_INSTR[15:8] == 8'h0E |-> ##4
    (O_DONE && O_ACC == $past(I_INSTR[7:0], 4))) else $error("literal load");
  a_store_write: assert property (st |-> ##1 O_MEM_REQ.rd ##2 (O_MEM_REQ.wr && O_MEM_REQ.wdata == O_ACC)
    ##1 (O_DONE && $stable(O_ACC))) else $error("store write");
  a_bank_addr: assert property (st && I_INSTR[8] |=>
    O_MEM_REQ.addr == {$past(I_BANK_SEL), $past(I_INSTR[7:0])}) else $error("banked address");
  a_access_addr: assert property (st && !I_INSTR[8] && !idx |=>
    O_MEM_REQ.addr == {$past(I_INSTR[7]) ? 4'hF : 4'h0, $past(I_INSTR[7:0])}) else $error("access address");
  a_indexed_addr: assert property (st && !I_INSTR[8] && idx |=>
    O_MEM_REQ.addr == $past(I_INDEX_BASE) + 12'($past(I_INSTR[7:0]))) else $error("indexed address");
  a_flags_quiet: assert property (!O_FLAGS_WE) else $error("flags written");
  a_mul_lit: assert property (take && I_INSTR[15:8] == 8'h0D |-> ##4
    {O_PROD_HI, O_PROD_LO} == 16'($past(O_ACC, 4)) * 16'($past(I_INSTR[7:0], 4))) else $error("multiply literal");
  // Operand byte stands on the read bus during Q3, two cycles before the check
  a_mul_file: assert property (take && I_INSTR[15:9] == 7'h01 |-> ##4
    {O_PROD_HI, O_PROD_LO} == 16'($past(O_ACC, 4)) * 16'($past(I_MEM_RDATA, 2))) else $error("multiply file");
  a_idle_quiet: assert property (O_PHASE == bmm_pkg::BMM_Q1 && !I_INSTR_VALID |-> ##4
    (!O_DONE && !O_ILLEGAL)) else $error("idle group flagged");
endmodule // bmm_exec_checker

bind bmm_exec bmm_exec_checker #(.DATA_W(DATA_W)) chk_u (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_INSTR_VALID(I_INSTR_VALID), .I_INSTR(I_INSTR), .I_EXT_EN(I_EXT_EN), .I_BANK_SEL(I_BANK_SEL),
  .I_INDEX_BASE(I_INDEX_BASE), .I_MEM_RDATA(I_MEM_RDATA), .O_MEM_REQ(O_MEM_REQ), .O_PHASE(O_PHASE),
  .O_ACC(O_ACC), .O_PROD_HI(O_PROD_HI), .O_PROD_LO(O_PROD_LO), .O_FLAGS_WE(O_FLAGS_WE),
  .O_DONE(O_DONE), .O_ILLEGAL(O_ILLEGAL));

// ===== verif/bmm_mem_model.sv
// Data-memory partner with one-cycle read latency.
// Assumes the request struct of the execution block.
`timescale 1ns/1ns
module bmm_mem_model (
  input wire logic             i_clk,
  input bmm_pkg::bmm_mem_req_t i_req,
  output logic [7:0]           o_rdata
);
  logic [7:0] mem [4096];
  initial o_rdata = 8'h00;
  // ====
  // Outside a read the bus toggles, so stale data never looks valid
  always @(posedge i_clk) begin
    if (i_req.wr) mem[i_req.addr] <= i_req.wdata;
    o_rdata <= i_req.rd ? mem[i_req.addr] : ~o_rdata;
  end
endmodule // bmm_mem_model

// ===== verif/test_bmm_exec.sv
// Self-checking bench for the execution block and its memory partner.
// Assumes the checker is bound in and the memory model is compiled.
`timescale 1ns/1ns
module test_bmm_exec;
  logic                  clk = 1'b0, rst = 1'b1, vld = 1'b0, ext = 1'b0, fwe, done, ill, d, il;
  logic [15:0]           instr = 16'h0000;
  logic [3:0]            bank = 4'h3;
  logic [11:0]           base = 12'h100;
  logic [7:0]            rdata, acc, phi, plo;
  bmm_pkg::bmm_mem_req_t req;
  bmm_pkg::bmm_phase_t   phase;
  int                    err_total = 0, cmp_count = 0;
  always #4 clk = ~clk;
  bmm_exec dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_INSTR_VALID(vld), .I_INSTR(instr), .I_EXT_EN(ext),
    .I_BANK_SEL(bank), .I_INDEX_BASE(base), .I_MEM_RDATA(rdata), .O_MEM_REQ(req), .O_PHASE(phase),
    .O_ACC(acc), .O_PROD_HI(phi), .O_PROD_LO(plo), .O_FLAGS_WE(fwe), .O_DONE(done), .O_ILLEGAL(ill));
  bmm_mem_model mem_u (.i_clk(clk), .i_req(req), .o_rdata(rdata));
  // ====
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Presents one word in Q1, then waits a bounded time for the outcome
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    d = 1'b0;
    il = 1'b0;
    @(negedge clk);
    while (phase !== bmm_pkg::BMM_Q4 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      err_total++;
      final_report();
    end
    @(posedge clk);
    vld <= 1'b1;
    instr <= w;
    @(posedge clk);
    vld <= 1'b0;
    for (n = 0; n < 6 && !d && !il; n++) begin
      @(negedge clk);
      d = (done === 1'b1);
      il = (ill === 1'b1);
    end
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(16'(acc), 16'h0000);
    check({phi, plo}, 16'h0000);
    check(16'(phase), 16'h0001);
  endtask
  task automatic t_lit();
    logic [7:0] kv [3];
    kv = '{8'h00, 8'hFF, 8'h5A};
    for (int i = 0; i < 3; i++) begin
      exec({8'h0E, kv[i]});
      check(16'(d), 16'h0001);
      check(16'(acc), 16'(kv[i]));
    end
  endtask
  task automatic t_store();
    logic [15:0] sw [7];
    logic [11:0] ea [7];
    sw = '{16'h6FFF, 16'h6F00, 16'h6E7F, 16'h6E80, 16'h6E5F, 16'h6E60, 16'h6E01};
    ea = '{12'h3FF, 12'h300, 12'h07F, 12'hF80, 12'h15F, 12'h060, 12'h000};
    for (int i = 0; i < 7; i++) begin
      exec({8'h0E, 8'h40 + 8'(i)});
      @(posedge clk);
      ext <= (i >= 4);
      base <= (i == 6) ? 12'hFFF : 12'h100;
      mem_u.mem[ea[i]] = 8'h00;
      exec(sw[i]);
      check(16'(d), 16'h0001);
      check(16'(mem_u.mem[ea[i]]), 16'h0040 + 16'(i));
      check(16'(acc), 16'h0040 + 16'(i));
    end
  endtask
  task automatic t_illegal();
    logic q;
    exec(16'hFFFF);
    check({15'h0000, il}, 16'h0001);
    check({15'h0000, d}, 16'h0000);
    // Idle groups after it must raise neither pulse
    q = 1'b0;
    repeat (8) begin
      @(negedge clk);
      q = q | (ill !== 1'b0) | (done !== 1'b0);
    end
    check({15'h0000, q}, 16'h0000);
  endtask
  task automatic t_mul();
    @(posedge clk);
    ext <= 1'b0;
    mem_u.mem[12'h3A5] = 8'h03;
    exec(16'h0EFF);
    exec(16'h0DFF);
    check({phi, plo}, 16'hFE01);
    exec(16'h03A5);
    check({phi, plo}, 16'h02FD);
    check(16'(acc), 16'h00FF);
    check(16'(mem_u.mem[12'h3A5]), 16'h0003);
  endtask
  initial begin
    t_reset();
    t_lit();
    t_store();
    t_illegal();
    t_mul();
    // Mid-run reset starts on a rising edge, then the core must run again
    @(posedge clk);
    t_reset();
    t_lit();
    final_report();
  end
  // Hang guard well beyond the longest sequence
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule // test_bmm_exec
